/* logic/seew_cfg.svh */
// constants of the serial eeprom command block
`ifndef SEEW_CFG_SVH
`define SEEW_CFG_SVH

// ---------------------------------------------------------------
// command byte layout
// ---------------------------------------------------------------
`define SEEW_OP_HI_ZERO   4'h0
`define SEEW_OP_ENABLE    3'h6
`define SEEW_OP_DISABLE   3'h4
`define SEEW_OP_STS_RD    3'h5
`define SEEW_OP_STS_WR    3'h1
`define SEEW_OP_ARR_RD    3'h3
`define SEEW_OP_ARR_WR    3'h2
`define SEEW_OP_A8_BIT    3

// ---------------------------------------------------------------
// status byte layout
// ---------------------------------------------------------------
`define SEEW_STS_ONES     4'hf
`define SEEW_STS_PROT_HI  3
`define SEEW_STS_PROT_LO  2
`define SEEW_PROT_RESET   2'h0

// ---------------------------------------------------------------
// protect codes, frame lengths in bytes and last bit index
// ---------------------------------------------------------------
`define SEEW_PROT_NONE    2'h0
`define SEEW_PROT_QUARTER 2'h1
`define SEEW_PROT_HALF    2'h2
`define SEEW_PROT_ALL     2'h3
`define SEEW_LEN_SHORT    3'h1
`define SEEW_LEN_STS_WR   3'h2
`define SEEW_LEN_ARR_MIN  3'h3
`define SEEW_LEN_MAX      3'h7
`define SEEW_BIT_LAST     3'h7

// ---------------------------------------------------------------
// timing and page size
// ---------------------------------------------------------------
`define SEEW_CLK_MHZ      20
`define SEEW_PROG_TIME_US 5000
`define SEEW_PAGE_BYTES   16

`endif

/* logic/seew_pkg.sv */
// types of the serial eeprom command block
`default_nettype none
package seew_pkg;

    // frame states of the command engine
    typedef enum logic [2:0] {
        SEEW_ST_CMD  = 3'b000,
        SEEW_ST_ADDR = 3'b001,
        SEEW_ST_RD   = 3'b010,
        SEEW_ST_SRD  = 3'b011,
        SEEW_ST_SWR  = 3'b100,
        SEEW_ST_AWR  = 3'b101,
        SEEW_ST_SKIP = 3'b110
    } seew_state_t;

    // pins arriving from the host side, all asynchronous
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic hold_n;
        logic low_supply;
    } seew_pins_t;

endpackage
`default_nettype wire

/* logic/seew_sync.sv */
// two flip-flop synchroniser for the pin group
`timescale 1ns/1ps
`default_nettype none
module seew_sync #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // seew_sync
`default_nettype wire

/* logic/seew_top.sv */
// serial eeprom command engine: status, array read/write, protect, pause
//
// Functional notes
// - status read repeats the status byte until chip select rises
// - status read is taken at any time, also while programming
// - protect bits keep old values until the status cycle completes
// - upper four status bits always read one
// - status write changes only the two protect bits
// - status write needs exactly 16 clocks, else it is dropped
// - busy is one during status programming; latch clears at completion
// - array read loads address, outputs, increments, wraps; A8 in opcode
// - chip select rise ends a read; read ignored while busy
// - array programming starts on rise after whole byte; clears busy, latch
// - page write increments low four address bits only, wrapping
// - array write refused: latch clear, busy, protected, protect pin low
// - array write dropped unless clocks equal 16 plus one or more whole bytes
// - protect codes: none, top quarter, top half, whole array
// - protect pin low blocks writes and clears the latch
// - paused: output floats, clock and data are ignored
// - clock low: pause follows the pause pin at once
// - clock high: pause change waits for next falling clock
// - chip select rise during pause ends the operation
// - low supply or power-on aborts programming and clears latch
// - busy reads one only during any programming cycle
// - one byte commands, msb first, after chip select falls
// - unknown command byte: ignore the rest of the frame
// - status byte: protect at 3:2, latch at 1, busy at 0
`timescale 1ns/1ps
`default_nettype none
`include "seew_cfg.svh"
module seew_top #(
    parameter int ADDR_W      = 9,
    parameter int PROG_CYCLES = `SEEW_PROG_TIME_US * `SEEW_CLK_MHZ
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // spi link from the host
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    output logic      so,
    output logic      so_oe,
    // protect, pause and supply monitor
    input  wire logic wp_n,
    input  wire logic hold_n,
    input  wire logic low_supply
);
    import seew_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;
    localparam int PAGE  = `SEEW_PAGE_BYTES;

    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    seew_pins_t pins_raw;
    seew_pins_t pins_s;

    assign pins_raw = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n,
                        hold_n: hold_n, low_supply: low_supply};

    seew_sync #(
        .W ($bits(seew_pins_t))
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .async_i (pins_raw),
        .sync_o  (pins_s)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    seew_state_t        state_q,   state_d;
    logic               sck_q,     sck_d;
    logic               cs_q,      cs_d;
    logic               paused_q,  paused_d;
    logic [2:0]         bit_q,     bit_d;
    logic [2:0]         nbyte_q,   nbyte_d;
    logic [7:0]         rx_q,      rx_d;
    logic [7:0]         tx_q,      tx_d;
    logic               so_q,      so_d;
    logic               oe_q,      oe_d;
    logic               a8_q,      a8_d;
    logic               rd_kind_q, rd_kind_d;
    logic               wr_ok_q,   wr_ok_d;
    logic [ADDR_W-1:0]  addr_q,    addr_d;
    logic [1:0]         prot_q,    prot_d;
    logic [1:0]         pend_q,    pend_d;
    logic               wel_q,     wel_d;
    logic               prog_arr_q, prog_arr_d;
    logic               prog_sts_q, prog_sts_d;
    logic [23:0]        timer_q,   timer_d;

    // array and page buffer, written by their own process
    logic [7:0]         mem_q  [DEPTH];
    logic [7:0]         pbuf_q [PAGE];
    logic [PAGE-1:0]    pmask_q;
    logic               buf_we;
    logic               buf_clr;
    logic               commit;

    logic               busy;
    logic               cs_rise;
    logic               sck_rise;
    logic               sck_fall;
    logic [7:0]         byte_in;
    logic [7:0]         sts_byte;
    logic [8:0]         addr_full;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // decodes the protect code against one address
    function automatic logic is_protected(input logic [1:0] code,
                                          input logic [ADDR_W-1:0] a);
        case (code)
            `SEEW_PROT_NONE:    is_protected = 1'b0;
            `SEEW_PROT_QUARTER: is_protected = &a[ADDR_W-1:ADDR_W-2];
            `SEEW_PROT_HALF:    is_protected = a[ADDR_W-1];
            default:            is_protected = 1'b1;
        endcase
    endfunction

    assign busy     = prog_arr_q | prog_sts_q;
    assign sts_byte = {`SEEW_STS_ONES, prot_q, wel_q, busy};
    assign cs_rise  = pins_s.cs_n & ~cs_q;
    // edges count only while selected and not paused
    assign sck_rise = pins_s.sck & ~sck_q & ~pins_s.cs_n & ~paused_q & ~paused_d;
    // the fall that starts a pause still shifts, so no output bit is lost
    assign sck_fall = ~pins_s.sck & sck_q & ~pins_s.cs_n & ~paused_q;
    assign byte_in  = {rx_q[6:0], pins_s.si};
    assign addr_full = {a8_q, byte_in};

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        sck_d      = pins_s.sck;
        cs_d       = pins_s.cs_n;
        paused_d   = paused_q;
        bit_d      = bit_q;
        nbyte_d    = nbyte_q;
        rx_d       = rx_q;
        tx_d       = tx_q;
        so_d       = so_q;
        oe_d       = oe_q;
        a8_d       = a8_q;
        rd_kind_d  = rd_kind_q;
        wr_ok_d    = wr_ok_q;
        addr_d     = addr_q;
        prot_d     = prot_q;
        pend_d     = pend_q;
        wel_d      = wel_q;
        prog_arr_d = prog_arr_q;
        prog_sts_d = prog_sts_q;
        timer_d    = timer_q;
        buf_we     = 1'b0;
        buf_clr    = 1'b0;
        commit     = 1'b0;

        // pause follows the pin only while the clock is low
        if (pins_s.cs_n) begin
            paused_d = 1'b0;
        end else if ((~pins_s.hold_n != paused_q) && !pins_s.sck) begin
            paused_d = ~pins_s.hold_n;
        end

        // programming timer; completion latches results
        if (busy) begin
            if (timer_q != 24'h0) begin
                timer_d = timer_q - 24'h1;
            end else begin
                commit     = prog_arr_q;
                prog_arr_d = 1'b0;
                prog_sts_d = 1'b0;
                wel_d      = 1'b0;
                if (prog_sts_q) begin
                    prot_d = pend_q;
                end
            end
        end

        // receive on rising clock, msb first
        if (sck_rise) begin
            rx_d  = byte_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == `SEEW_BIT_LAST && nbyte_q != `SEEW_LEN_MAX) begin
                nbyte_d = nbyte_q + 3'h1;
            end
            if (bit_q == `SEEW_BIT_LAST) begin
                case (state_q)
                    SEEW_ST_CMD: begin
                        a8_d = byte_in[`SEEW_OP_A8_BIT];
                        if (byte_in[7:4] != `SEEW_OP_HI_ZERO) begin
                            state_d = SEEW_ST_SKIP;
                        end else begin
                            case (byte_in[2:0])
                                `SEEW_OP_ENABLE, `SEEW_OP_DISABLE: begin
                                    state_d = SEEW_ST_SKIP; // acts at cs rise
                                end
                                `SEEW_OP_STS_RD: begin
                                    state_d = SEEW_ST_SRD;
                                    tx_d    = sts_byte;
                                end
                                `SEEW_OP_STS_WR: begin
                                    state_d = SEEW_ST_SWR;
                                end
                                `SEEW_OP_ARR_RD: begin
                                    state_d   = busy ? SEEW_ST_SKIP : SEEW_ST_ADDR;
                                    rd_kind_d = 1'b1;
                                end
                                `SEEW_OP_ARR_WR: begin
                                    state_d   = SEEW_ST_ADDR;
                                    rd_kind_d = 1'b0;
                                end
                                default: state_d = SEEW_ST_SKIP;
                            endcase
                        end
                    end
                    SEEW_ST_ADDR: begin
                        addr_d = busy ? addr_q : addr_full[ADDR_W-1:0];
                        if (rd_kind_q) begin
                            state_d = SEEW_ST_RD;
                            tx_d    = mem_q[addr_full[ADDR_W-1:0]];
                        end else begin
                            state_d = SEEW_ST_AWR;
                            buf_clr = ~busy; // keep the page being programmed
                            wr_ok_d = wel_q & ~busy & pins_s.wp_n
                                & ~is_protected(prot_q, addr_full[ADDR_W-1:0]);
                        end
                    end
                    SEEW_ST_RD: begin
                        addr_d = addr_q + 1'b1;      // wraps at the top
                        tx_d   = mem_q[addr_q + 1'b1];
                    end
                    SEEW_ST_SRD: begin
                        tx_d = sts_byte;
                    end
                    SEEW_ST_SWR: begin
                        pend_d = byte_in[`SEEW_STS_PROT_HI:`SEEW_STS_PROT_LO];
                    end
                    SEEW_ST_AWR: begin
                        buf_we = wr_ok_q;
                        addr_d = {addr_q[ADDR_W-1:4], addr_q[3:0] + 4'h1};
                    end
                    default: ;
                endcase
            end
        end

        // drive on falling clock while a read is shifting out
        if (sck_fall && (state_q == SEEW_ST_RD || state_q == SEEW_ST_SRD)) begin
            so_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = 1'b1;
        end
        if (paused_d) begin
            oe_d = 1'b0;
        end else if (!pins_s.cs_n && !paused_q && oe_q == 1'b0
                     && state_q != SEEW_ST_CMD && bit_q != 3'h0
                     && (state_q == SEEW_ST_RD || state_q == SEEW_ST_SRD)) begin
            oe_d = 1'b1; // resume after pause
        end

        // frame end decides on the clock count
        if (cs_rise) begin
            state_d = SEEW_ST_CMD;
            bit_d   = 3'h0;
            nbyte_d = 3'h0;
            oe_d    = 1'b0;
            if (bit_q == 3'h0 && !busy) begin
                if (nbyte_q == `SEEW_LEN_SHORT && rx_q[7:4] == `SEEW_OP_HI_ZERO) begin
                    if (rx_q[2:0] == `SEEW_OP_ENABLE) begin
                        wel_d = 1'b1;
                    end
                    if (rx_q[2:0] == `SEEW_OP_DISABLE) begin
                        wel_d = 1'b0;
                    end
                end
                if (state_q == SEEW_ST_SWR && nbyte_q == `SEEW_LEN_STS_WR
                    && wel_q && pins_s.wp_n) begin
                    prog_sts_d = 1'b1;
                    timer_d    = 24'(PROG_CYCLES - 1);
                end
                if (state_q == SEEW_ST_AWR && wr_ok_q
                    && nbyte_q >= `SEEW_LEN_ARR_MIN) begin
                    prog_arr_d = 1'b1;
                    timer_d    = 24'(PROG_CYCLES - 1);
                end
            end
        end

        // protect pin and low supply clear the latch; supply aborts work
        if (!pins_s.wp_n) begin
            wel_d = 1'b0;
        end
        if (pins_s.low_supply) begin
            wel_d      = 1'b0;
            prog_arr_d = 1'b0;
            prog_sts_d = 1'b0;
            commit     = 1'b0;
            prot_d     = prot_q;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // power-on reset also clears the latch and any programming
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= SEEW_ST_CMD;
            sck_q      <= 1'b0;
            cs_q       <= 1'b1;
            paused_q   <= 1'b0;
            bit_q      <= 3'h0;
            nbyte_q    <= 3'h0;
            rx_q       <= 8'h00;
            tx_q       <= 8'h00;
            so_q       <= 1'b0;
            oe_q       <= 1'b0;
            a8_q       <= 1'b0;
            rd_kind_q  <= 1'b0;
            wr_ok_q    <= 1'b0;
            addr_q     <= '0;
            prot_q     <= `SEEW_PROT_RESET;
            pend_q     <= `SEEW_PROT_RESET;
            wel_q      <= 1'b0;
            prog_arr_q <= 1'b0;
            prog_sts_q <= 1'b0;
            timer_q    <= 24'h0;
        end else begin
            state_q    <= state_d;
            sck_q      <= sck_d;
            cs_q       <= cs_d;
            paused_q   <= paused_d;
            bit_q      <= bit_d;
            nbyte_q    <= nbyte_d;
            rx_q       <= rx_d;
            tx_q       <= tx_d;
            so_q       <= so_d;
            oe_q       <= oe_d;
            a8_q       <= a8_d;
            rd_kind_q  <= rd_kind_d;
            wr_ok_q    <= wr_ok_d;
            addr_q     <= addr_d;
            prot_q     <= prot_d;
            pend_q     <= pend_d;
            wel_q      <= wel_d;
            prog_arr_q <= prog_arr_d;
            prog_sts_q <= prog_sts_d;
            timer_q    <= timer_d;
        end
    end

    // ---------------------------------------------------------------
    // page buffer and array
    // ---------------------------------------------------------------
    // array has no reset: contents are nonvolatile; the page is only
    // written into the array when the whole frame was accepted
    always_ff @(posedge clk_sys) begin
        if (buf_clr) begin
            pmask_q <= '0;
        end else if (buf_we) begin
            pbuf_q[addr_q[3:0]]  <= byte_in;     // overwrite on wrap
            pmask_q[addr_q[3:0]] <= 1'b1;
        end
        if (commit) begin
            for (int i = 0; i < PAGE; i++) begin
                if (pmask_q[i]) begin
                    mem_q[{addr_q[ADDR_W-1:4], 4'(i)}] <= pbuf_q[i];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign so    = so_q;
    assign so_oe = oe_q;
endmodule // seew_top
`default_nettype wire

/* sim/seew_top_asserts.sv */
// port-level checks of the serial eeprom command engine
`timescale 1ns/1ps
`default_nettype none
`include "seew_cfg.svh"
module seew_top_asserts #(
    parameter int ADDR_W      = 9,
    parameter int PROG_CYCLES = 100
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // spi link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    // protect, pause and supply monitor
    input wire logic wp_n,
    input wire logic hold_n,
    input wire logic low_supply
);
    logic       sck_q;
    logic [3:0] nrise_q, nrise_d;
    logic [7:0] cmd_q, cmd_d;
    logic [5:0] ev_q, ev_d;

    // raw pin view: it leads the engine's synchronised view, so bounds stay safe
    always_comb begin
        nrise_d = nrise_q;
        cmd_d   = cmd_q;
        if (cs_n) begin
            nrise_d = 4'h0;
        end else if (sck && !sck_q && nrise_q != 4'hf) begin
            nrise_d = nrise_q + 4'h1;
            if (nrise_q < 4'h8) begin
                cmd_d = {cmd_q[6:0], si};
            end
        end
        ev_d = {ev_q[4:0], cs_n | ~hold_n};  // recent deselect or pause request
    end

    // helper registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_q   <= 1'b0;
            nrise_q <= 4'h0;
            cmd_q   <= 8'h00;
            ev_q    <= 6'h00;
        end else begin
            sck_q   <= sck;
            nrise_q <= nrise_d;
            cmd_q   <= cmd_d;
            ev_q    <= ev_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // output drive follows select, pause and the command byte
    AST_DESEL_FLOAT: assert property (cs_n [*5] |-> !so_oe)
        else $error("so_oe still high after deselect");
    AST_PAUSE_FLOAT: assert property ((!hold_n && !sck) [*6] |-> !so_oe)
        else $error("so_oe high while paused with sck low");
    AST_PAUSE_WAITS_FALL: assert property ((!cs_n && so_oe && sck) [*4] ##1
        (!cs_n && sck && !hold_n) [*3] |-> so_oe)
        else $error("pause taken while sck high");
    AST_SO_STEADY_HIGH: assert property ((sck && !cs_n) [*5] |-> $stable(so))
        else $error("so changed while sck high");
    AST_OE_ONLY_READS: assert property ($rose(so_oe) |-> nrise_q >= 4'h8 && !sck &&
        cmd_q[7:4] == `SEEW_OP_HI_ZERO &&
        (cmd_q[2:0] == `SEEW_OP_STS_RD || cmd_q[2:0] == `SEEW_OP_ARR_RD))
        else $error("so_oe rose without a read command");
    AST_BAD_CMD_SILENT: assert property (nrise_q >= 4'h8 && cmd_q[7:4] != 4'h0
        |-> !so_oe)
        else $error("so_oe high after unknown command");
    AST_STS_FIRST_ONE: assert property ($rose(so_oe) && nrise_q == 4'h8 &&
        cmd_q[2:0] == `SEEW_OP_STS_RD |=> so)
        else $error("status byte top bit not one");
    AST_OE_FALL_CAUSE: assert property ($fell(so_oe) |-> |ev_q)
        else $error("so_oe fell without deselect or pause");

    // main scenarios
    COV_READ: cover property ($rose(so_oe));
    COV_PAUSE: cover property ($fell(so_oe) && !cs_n);
    COV_SUPPLY: cover property ($rose(low_supply));
    COV_WP: cover property (!wp_n && !cs_n);
endmodule // seew_top_asserts

bind seew_top seew_top_asserts #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) u_asserts (
    .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n), .low_supply(low_supply));
`default_nettype wire

/* sim/seew_host.sv */
// spi host model in mode 0 facing the command engine
`timescale 1ns/1ps
`default_nettype none
module seew_host (
    // pacing clock
    input  wire logic clk_sys,
    // spi link
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    int   half;
    logic oe_any;

    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        half   = 4;
        oe_any = 1'b0;
    end

    // idle data toggles so a stale level is never taken for data
    always @(negedge clk_sys) if (cs_n) si <= ~si;

    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic sel();
        oe_any = 1'b0;
        cs_n   = 1'b0;
        wt(half);
    endtask

    // msb first from the top of tx, so taken at each rising sck
    task automatic bits(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        for (int i = 0; i < n; i++) begin
            si = tx[63-i];
            wt(half);
            sck    = 1'b1;
            rx     = {rx[62:0], so_oe ? so : ~so};  // floating output reads wrong
            oe_any = oe_any | so_oe;
            wt(half);
            sck = 1'b0;
        end
    endtask

    // raised before the next rising sck, so a write frame starts programming
    task automatic desel();
        cs_n = 1'b1;
        wt(2 * half);
    endtask

    task automatic run(input logic [63:0] tx, input int n, output logic [63:0] rx);
        sel();
        bits(tx, n, rx);
        desel();
    endtask
endmodule // seew_host
`default_nettype wire

/* sim/spi_eeprom_status_read_write_test.sv */
// self-checking bench of the serial eeprom command engine
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_status_read_write_test;
    import seew_pkg::*;
    localparam int PROG = 400;  // short programming time keeps the run brief
    logic        clk_sys, rst_n, wp_n, hold_n, low_supply;
    wire logic   cs_n, sck, si, so, so_oe;
    int          err_count, n_tests, cyc;
    logic [63:0] r;

    seew_top #(.ADDR_W(9), .PROG_CYCLES(PROG)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n), .low_supply(low_supply));
    seew_host u_host (
        .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    task automatic chk(input logic [7:0] v, input logic [7:0] e);
        n_tests++;
        if (v !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well above the roughly ten thousand cycles the tests need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            test_done();
        end
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    // two status bytes back to back
    task automatic st(input logic [7:0] e);
        u_host.run({8'h05, 56'h0}, 24, r);
        chk(r[15:8], e);
        chk(r[7:0], e);
    endtask
    task automatic wen();
        u_host.run({8'h06, 56'h0}, 8, r);
    endtask
    task automatic wr1(input logic [8:0] a, input logic [7:0] d);
        u_host.run({4'h0, a[8], 3'h2, a[7:0], d, 40'h0}, 24, r);
    endtask

    initial begin
        {rst_n, low_supply, err_count, n_tests, cyc} = '0;
        {wp_n, hold_n} = 2'b11;
        wt(16);
        rst_n = 1'b1;
        wt(4);
        st(8'hf0);
        chk({7'h0, so_oe}, 8'h00);
        u_host.run({8'h01, 8'hff, 48'h0}, 16, r);
        st(8'hf0);
        u_host.run({8'h0e, 56'h0}, 8, r);
        st(8'hf2);
        u_host.run({8'h04, 56'h0}, 8, r);
        st(8'hf0);
        fin("status_latch");
        wen();
        u_host.run({8'h0a, 8'hfe, 8'haa, 8'hbb, 8'hcc, 24'h0}, 40, r);
        u_host.run({8'h0b, 8'hfe, 48'h0}, 24, r);
        chk({7'h0, u_host.oe_any}, 8'h00);
        wt(PROG);
        st(8'hf0);
        wen();
        wr1(9'h000, 8'h5a);
        wt(PROG);
        u_host.run({8'h0b, 8'hfe, 48'h0}, 40, r);
        chk(r[23:16], 8'haa);
        chk(r[15:8], 8'hbb);
        chk(r[7:0], 8'h5a);
        u_host.run({8'h0b, 8'hf0, 48'h0}, 24, r);
        chk(r[7:0], 8'hcc);
        fin("page");
        wen();
        u_host.run({8'h01, 8'ha5, 48'h0}, 16, r);
        st(8'hf3);
        wt(PROG);
        st(8'hf4);
        wen();
        u_host.run({8'h01, 8'h08, 48'h0}, 17, r);
        wt(PROG);
        st(8'hf6);
        wr1(9'h180, 8'h11);
        st(8'hf6);
        wr1(9'h17f, 8'h22);
        st(8'hf7);
        wt(PROG);
        u_host.run({8'h0b, 8'h7f, 48'h0}, 24, r);
        chk(r[7:0], 8'h22);
        st(8'hf4);
        fin("protect");
        wen();
        u_host.run({8'h02, 8'h30, 8'h77, 40'h0}, 27, r);
        st(8'hf6);
        wp_n = 1'b0;
        wt(8);
        st(8'hf4);
        wen();
        wr1(9'h030, 8'h33);
        st(8'hf4);
        wp_n = 1'b1;
        wen();
        wr1(9'h040, 8'h44);
        low_supply = 1'b1;
        wt(8);
        low_supply = 1'b0;
        wt(8);
        st(8'hf4);
        for (int i = 0; i < 2; i++) begin
            u_host.run({(i == 0) ? 8'h85 : 8'h07, 8'h05, 48'h0}, 24, r);
            chk({7'h0, u_host.oe_any}, 8'h00);
        end
        fin("refusals");
        u_host.half = 10;
        u_host.sel();
        u_host.bits({8'h05, 56'h0}, 8, r);
        fork
            u_host.bits(64'h0, 1, r);
            begin
                @(posedge sck);
                wt(4);
                hold_n = 1'b0;
                wt(4);
                chk({7'h0, so_oe}, 8'h01);
            end
        join
        wt(8);
        chk({7'h0, so_oe}, 8'h00);
        hold_n = 1'b1;
        wt(8);
        chk({7'h0, so_oe}, 8'h01);
        u_host.bits(64'h0, 15, r);
        chk(r[7:0], 8'hf4);
        chk({1'b0, r[14:8]}, 8'h74);
        u_host.desel();
        u_host.half = 4;
        fin("pause");
        test_done();
    end
endmodule // spi_eeprom_status_read_write_test
`default_nettype wire
